// File: include/fma_pkg.sv
// Constants, mode codes and lane layout for the fracturable multiply-accumulate block.
// Assumes a single fabric clock; all operands and controls come from fabric logic.
//
// How it works
// [RULE1] Multiply, add, subtract, accumulate, 4-bit right shift
// [RULE2] Shifter has one, two or four lanes
// [RULE3] Exactly one of four operating modes
// [RULE4] Single mode: 19x18 product, 48-bit add/sub
// [RULE5] Dual mode: 11x10 and 8x8, 24-bit lanes
// [RULE6] Quad mode: 7x6 plus three 4x4, 12-bit lanes
// [RULE7] Float mode: brain-float fused multiply-add
// [RULE8] Static setting picks signed or unsigned operands
// [RULE9] Packed instances share one signedness setting
// [RULE10] Factors come from two dedicated operand inputs
// [RULE11] Adder optional; bypass presents raw product
// [RULE12] Accumulator register updates each edge, reset clears
// [RULE13] Each lane chooses add or subtract per operation

package fma_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMA_MODE_SINGLE,
    FMA_MODE_DUAL,
    FMA_MODE_QUAD,
    FMA_MODE_FLOAT
  } fma_mode_t;

  // Adder stage operation
  typedef enum logic [1:0] {
    FMA_OP_BYPASS,
    FMA_OP_ADD,
    FMA_OP_ACCUM
  } fma_op_t;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int FMA_A_W = 19;
  localparam int FMA_B_W = 18;
  localparam int FMA_SUM_W = 48;
  localparam int FMA_SHIFT_W = 4;

  // Dual lanes
  localparam int FMA_D0_AW = 11;
  localparam int FMA_D0_BW = 10;
  localparam int FMA_D1_AW = 8;
  localparam int FMA_D1_BW = 8;
  localparam int FMA_DUAL_LANE_W = 24;

  // Quad lanes
  localparam int FMA_Q0_AW = 7;
  localparam int FMA_Q0_BW = 6;
  localparam int FMA_QN_W = 4;
  localparam int FMA_QUAD_LANE_W = 12;

  // Brain-float fields
  localparam int FMA_BF_W = 16;
  localparam int FMA_BF_EXP_W = 8;
  localparam int FMA_BF_MAN_W = 7;
  localparam logic [7:0] FMA_BF_BIAS = 8'h7f;
  localparam logic [7:0] FMA_BF_EXP_MAX = 8'hff;

  // Reset value of the result register
  localparam logic [47:0] FMA_RESULT_RESET = 48'h0;

endpackage

// File: logic/fma_block.sv
// Fracturable multiply-accumulate datapath: one, two or four integer lanes,
// or a single brain-float fused multiply-add. One register stage at the output.
// Assumes operands and controls are driven synchronously by fabric logic.
`timescale 1ns/100ps
`default_nettype none

module fma_block #(
  parameter int SUM_W = 48
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Static configuration
  input wire logic [1:0] mode_in,
  input wire logic signed_in,
  // Per-operation controls
  input wire logic [1:0] op_in,
  input wire logic [3:0] sub_in,
  input wire logic [15:0] shift_in,
  // Operands
  input wire logic [18:0] a_in,
  input wire logic [17:0] b_in,
  input wire logic [47:0] c_in,
  // Result
  output logic [47:0] result_out
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Extend a factor of given width to 24 bits, signed or unsigned
  function automatic logic [23:0] fma_ext(input logic [23:0] v, input int w, input logic sgn);
    logic [23:0] r;
    r = 24'h0;
    for (int i = 0; i < 24; i++) begin
      if (i < w) begin
        r[i] = v[i];
      end else begin
        r[i] = sgn & v[w-1];
      end
    end
    return r;
  endfunction

  // Product of two extended factors, kept to 48 bits
  function automatic logic [47:0] fma_mul(input logic [23:0] x, input logic [23:0] y, input logic sgn);
    logic [47:0] p;
    if (sgn) begin
      p = 48'($signed(x) * $signed(y));
    end else begin
      p = 48'(x * y);
    end
    return p;
  endfunction

  // Add or subtract, then right shift (arithmetic when signed)
  function automatic logic [47:0] fma_lane(input logic [47:0] p, input logic [47:0] c,
                                            input logic use_add, input logic sub,
                                            input logic [3:0] sh, input logic sgn, input int w);
    logic [47:0] s;
    logic [47:0] mask;
    mask = (48'h1 << w) - 48'h1;
    s = p;
    if (use_add) begin
      s = sub ? (c - p) : (c + p);
    end
    s = s & mask;
    if (sgn && s[w-1]) begin
      s = s | ~mask;
    end
    s = sgn ? 48'($signed(s) >>> sh) : (s >> sh);
    return s & mask;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  fma_pkg::fma_mode_t mode;   // Exactly one mode at a time [RULE3]
  fma_pkg::fma_op_t op;
  logic use_add;              // Adder stage in use [RULE11]
  logic [47:0] addend;        // Accumulator or fabric addend [RULE12]

  assign mode = fma_pkg::fma_mode_t'(mode_in);
  assign op = fma_pkg::fma_op_t'(op_in);
  assign use_add = (op == fma_pkg::FMA_OP_ADD) || (op == fma_pkg::FMA_OP_ACCUM);
  assign addend = (op == fma_pkg::FMA_OP_ACCUM) ? result_out : c_in;

  // ----------------------------------------------------------------
  // Integer lanes
  // ----------------------------------------------------------------
  // Signedness is one static bit for the whole block, so lanes packed
  // together cannot disagree [RULE8] [RULE9]. Factors come only from a_in
  // and b_in [RULE10].
  logic [47:0] next_single;
  logic [47:0] next_dual;
  logic [47:0] next_quad;
  logic [47:0] d0;
  logic [47:0] d1;
  logic [11:0] q0;
  logic [11:0] q1;
  logic [11:0] q2;
  logic [11:0] q3;

  // Single 19x18 product with 48-bit add/sub and one shift lane
  always_comb begin
    next_single = fma_lane(fma_mul(fma_ext(24'(a_in), fma_pkg::FMA_A_W, signed_in),
                                   fma_ext(24'(b_in), fma_pkg::FMA_B_W, signed_in), signed_in),
                           addend, use_add, sub_in[0], shift_in[3:0], signed_in,
                           SUM_W); // [RULE4] [RULE1] [RULE2] [RULE13]
  end

  // Dual: a[10:0]*b[9:0] in low 24 bits, a[18:11]*b[17:10] in high 24 bits
  always_comb begin
    d0 = fma_lane(fma_mul(fma_ext(24'(a_in[10:0]), fma_pkg::FMA_D0_AW, signed_in),
                          fma_ext(24'(b_in[9:0]), fma_pkg::FMA_D0_BW, signed_in), signed_in),
                  {24'h0, addend[23:0]}, use_add, sub_in[0], shift_in[3:0], signed_in,
                  fma_pkg::FMA_DUAL_LANE_W); // [RULE5] [RULE2] [RULE13]
    d1 = fma_lane(fma_mul(fma_ext(24'(a_in[18:11]), fma_pkg::FMA_D1_AW, signed_in),
                          fma_ext(24'(b_in[17:10]), fma_pkg::FMA_D1_BW, signed_in), signed_in),
                  {24'h0, addend[47:24]}, use_add, sub_in[1], shift_in[7:4], signed_in,
                  fma_pkg::FMA_DUAL_LANE_W); // [RULE5] [RULE2] [RULE13]
    next_dual = {d1[23:0], d0[23:0]};
  end

  // Quad: 7x6 in lane 0, three 4x4 in lanes 1 to 3, each 12 bits wide
  always_comb begin
    logic [47:0] t0;
    logic [47:0] t1;
    logic [47:0] t2;
    logic [47:0] t3;
    t0 = fma_lane(fma_mul(fma_ext(24'(a_in[6:0]), fma_pkg::FMA_Q0_AW, signed_in),
                          fma_ext(24'(b_in[5:0]), fma_pkg::FMA_Q0_BW, signed_in), signed_in),
                  {36'h0, addend[11:0]}, use_add, sub_in[0], shift_in[3:0], signed_in,
                  fma_pkg::FMA_QUAD_LANE_W); // [RULE6] [RULE2] [RULE13]
    t1 = fma_lane(fma_mul(fma_ext(24'(a_in[10:7]), fma_pkg::FMA_QN_W, signed_in),
                          fma_ext(24'(b_in[9:6]), fma_pkg::FMA_QN_W, signed_in), signed_in),
                  {36'h0, addend[23:12]}, use_add, sub_in[1], shift_in[7:4], signed_in,
                  fma_pkg::FMA_QUAD_LANE_W); // [RULE6] [RULE2] [RULE13]
    t2 = fma_lane(fma_mul(fma_ext(24'(a_in[14:11]), fma_pkg::FMA_QN_W, signed_in),
                          fma_ext(24'(b_in[13:10]), fma_pkg::FMA_QN_W, signed_in), signed_in),
                  {36'h0, addend[35:24]}, use_add, sub_in[2], shift_in[11:8], signed_in,
                  fma_pkg::FMA_QUAD_LANE_W); // [RULE6] [RULE2] [RULE13]
    t3 = fma_lane(fma_mul(fma_ext(24'(a_in[18:15]), fma_pkg::FMA_QN_W, signed_in),
                          fma_ext(24'(b_in[17:14]), fma_pkg::FMA_QN_W, signed_in), signed_in),
                  {36'h0, addend[47:36]}, use_add, sub_in[3], shift_in[15:12], signed_in,
                  fma_pkg::FMA_QUAD_LANE_W); // [RULE6] [RULE2] [RULE13]
    q0 = t0[11:0];
    q1 = t1[11:0];
    q2 = t2[11:0];
    q3 = t3[11:0];
    next_quad = {q3, q2, q1, q0};
  end

  // ----------------------------------------------------------------
  // Brain-float fused multiply-add
  // ----------------------------------------------------------------
  // Single rounding at the end (truncation), subnormals flush to zero,
  // no NaN/infinity handling beyond saturating the exponent. Trade-off:
  // small area in exchange for loose corner-case behaviour.
  logic [15:0] next_float;
  always_comb begin
    logic [15:0] fc;
    logic sp;
    logic [9:0] ep;
    logic [15:0] mp;
    logic [9:0] ec;
    logic [31:0] mx;
    logic [31:0] my;
    logic [9:0] ex;
    logic sx;
    logic sy;
    logic [9:0] d;
    logic [31:0] m;
    logic sr;
    logic [9:0] er;
    logic [5:0] lz;
    d = 10'h0;
    m = 32'h0;
    sr = 1'b0;
    er = 10'h0;
    fc = addend[15:0];
    sp = a_in[15] ^ b_in[15];
    ep = 10'(a_in[14:7]) + 10'(b_in[14:7]) - 10'(fma_pkg::FMA_BF_BIAS);
    mp = 16'({1'b1, a_in[6:0]}) * 16'({1'b1, b_in[6:0]});
    if ((a_in[14:7] == 8'h0) || (b_in[14:7] == 8'h0)) begin
      mp = 16'h0;
    end
    // Product bit 15 lands on bit 30, whose exponent is ep+1; bit 31 stays
    // clear as headroom so adding two magnitudes cannot carry out
    mx = {1'b0, mp, 15'h0};
    ex = ep + 10'h1;
    // Subtract negates the product: the result is addend minus product [RULE13]
    sx = sp ^ (use_add & sub_in[0]);
    // Addend aligned to the same format, hidden one on bit 30
    my = (fc[14:7] == 8'h0) ? 32'h0 : {2'b01, fc[6:0], 23'h0};
    ec = 10'(fc[14:7]);
    sy = fc[15];
    // Bypass: addend must not steer the alignment of the raw product [RULE11]
    if (!use_add) begin
      my = 32'h0;
      ec = 10'h0;
    end
    // Align smaller magnitude to larger exponent
    if ($signed(ex) < $signed(ec)) begin
      d = ec - ex;
      mx = (d > 10'd31) ? 32'h0 : (mx >> d[4:0]);
      er = ec;
    end else begin
      d = ex - ec;
      my = (d > 10'd31) ? 32'h0 : (my >> d[4:0]);
      er = ex;
    end
    if (sx == sy) begin
      m = mx + my;
      sr = sx;
    end else if (mx >= my) begin
      m = mx - my;
      sr = sx;
    end else begin
      m = my - mx;
      sr = sy;
    end
    // Normalise: leading one on bit 30 means exponent er, on bit 31 er+1
    lz = 6'h0;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        lz = 6'(31 - i);
      end
    end
    m = m << lz;
    er = er + 10'h1 - 10'(lz);
    if ((m == 32'h0) || $signed(er) <= 0) begin
      next_float = {sr & (m != 32'h0), 15'h0};
    end else if ($signed(er) >= $signed(10'(fma_pkg::FMA_BF_EXP_MAX))) begin
      next_float = {sr, fma_pkg::FMA_BF_EXP_MAX, 7'h0};
    end else begin
      next_float = {sr, er[7:0], m[30:24]};
    end
  end // [RULE7]

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  // Updates on every edge; synchronous reset clears the running sum
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      result_out <= fma_pkg::FMA_RESULT_RESET; // [RULE12]
    end else begin
      case (mode)
        fma_pkg::FMA_MODE_SINGLE: result_out <= next_single;
        fma_pkg::FMA_MODE_DUAL: result_out <= next_dual;
        fma_pkg::FMA_MODE_QUAD: result_out <= next_quad;
        fma_pkg::FMA_MODE_FLOAT: result_out <= {32'h0, next_float}; // [RULE3]
        default: result_out <= fma_pkg::FMA_RESULT_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_accum_step;
    op == fma_pkg::FMA_OP_ACCUM && mode == fma_pkg::FMA_MODE_SINGLE;
  endsequence

  a_reset_clears: assert property (@(posedge mclk_in) !rst_n_in |=> result_out == 48'h0) // [RULE12]
    else $error("result not cleared by reset");

  a_bypass_raw: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE11]
    (mode == fma_pkg::FMA_MODE_SINGLE && op == fma_pkg::FMA_OP_BYPASS && !signed_in && shift_in[3:0] == 4'h0)
    |=> result_out == 48'($past(a_in) * $past(b_in)))
    else $error("bypass did not present raw product");

  a_accum_sum: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE12]
    s_accum_step and (!sub_in[0] && shift_in[3:0] == 4'h0 && !signed_in)
    |=> result_out == 48'($past(result_out) + 48'($past(a_in) * $past(b_in))))
    else $error("accumulate sum wrong");

  a_sub_select: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE13]
    (mode == fma_pkg::FMA_MODE_SINGLE && op == fma_pkg::FMA_OP_ADD && sub_in[0] && !signed_in
     && shift_in[3:0] == 4'h0)
    |=> result_out == 48'($past(c_in) - 48'($past(a_in) * $past(b_in))))
    else $error("subtract selection wrong");

  a_quad_lane: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE6]
    (mode == fma_pkg::FMA_MODE_QUAD && op == fma_pkg::FMA_OP_BYPASS && !signed_in && shift_in == 16'h0)
    |=> result_out[23:12] == 12'($past(a_in[10:7]) * $past(b_in[9:6])))
    else $error("quad lane 1 product wrong");

  a_dual_lane: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE5]
    (mode == fma_pkg::FMA_MODE_DUAL && op == fma_pkg::FMA_OP_BYPASS && !signed_in && shift_in == 16'h0)
    |=> result_out[47:24] == 24'($past(a_in[18:11]) * $past(b_in[17:10])))
    else $error("dual lane 1 product wrong");

  a_shift_lane: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE2]
    (mode == fma_pkg::FMA_MODE_QUAD && op == fma_pkg::FMA_OP_BYPASS && !signed_in)
    |=> result_out[47:36] == 12'(($past(a_in[18:15]) * $past(b_in[17:14])) >> $past(shift_in[15:12])))
    else $error("quad lane 3 shift wrong");

  a_float_upper: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // [RULE7]
    mode == fma_pkg::FMA_MODE_FLOAT |=> result_out[47:16] == 32'h0)
    else $error("float result upper bits not zero");

endmodule

`default_nettype wire

// File: tb/fma_fabric.sv
// Fabric-side model for fma_block: holds the static setup and drives operands.
// Assumes the bench calls its tasks one small step after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module fma_fabric (
  // Static configuration
  output logic signed_out,
  // Per-operation controls
  output logic [1:0] mode_out,
  output logic [1:0] op_out,
  output logic [3:0] sub_out,
  output logic [15:0] shift_out,
  // Operands
  output logic [18:0] a_out,
  output logic [17:0] b_out,
  output logic [47:0] c_out
);
  // ----------------------------------------
  // Idle values at time zero
  // ----------------------------------------
  initial begin
    {signed_out, mode_out, op_out, sub_out, shift_out, a_out, b_out, c_out} = '0;
  end

  // One signedness for every lane packed in the block
  task automatic set_cfg(input logic s);
    signed_out = s;
  endtask

  // New operation; lines then hold until the next call
  task automatic put(input logic [1:0] m, input logic [1:0] o, input logic [3:0] su,
                     input logic [15:0] sh, input logic [18:0] x, input logic [17:0] y, input logic [47:0] z);
    mode_out = m;
    op_out = o;
    sub_out = su;
    shift_out = sh;
    a_out = x;
    b_out = y;
    c_out = z;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for fma_block: hand corners plus seeded random operations.
// Assumes fma_fabric drives every operand and control input and all drives happen 1 ns after the edge.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // ----------------------------------------
  // Clock, reset, model state and counters
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sgn = 1'b0;
  logic [1:0] mode, op, drv_mode, drv_op;
  logic [3:0] sub, drv_sub;
  logic [15:0] sh, drv_shift;
  logic [18:0] a, drv_a;
  logic [17:0] b, drv_b;
  logic [47:0] c, drv_c, result, prev, expv;
  logic drv_signed;
  logic [31:0] seed = 32'h0000c9f1; // 51697
  int err_total = 0;
  int checks = 0;
  int cycles = 0;

  fma_fabric i_fma_fabric (.signed_out(drv_signed), .mode_out(drv_mode), .op_out(drv_op), .sub_out(drv_sub),
    .shift_out(drv_shift), .a_out(drv_a), .b_out(drv_b), .c_out(drv_c));
  fma_block #(.SUM_W(48)) i_fma_block (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .mode_in(drv_mode),
    .signed_in(drv_signed), .op_in(drv_op), .sub_in(drv_sub), .shift_in(drv_shift), .a_in(drv_a),
    .b_in(drv_b), .c_in(drv_c), .result_out(result));

  // 25 ns period
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Hang guard: the whole run needs well under 1000 cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Keep w bits, sign-extend when signed
  function automatic longint ext(input longint x, input int w, input logic s);
    x = x & ((64'sd1 << w) - 1);
    return (s && x[w-1]) ? x - (64'sd1 << w) : x;
  endfunction

  // Integer lanes: product, optional add/sub, truncate, shift, truncate
  function automatic logic [47:0] model();
    int n, w, aw, bw, ao, bo;
    longint p, ca, s, t;
    logic [47:0] r;
    r = '0;
    ao = 0;
    bo = 0;
    n = (mode == 2'h0) ? 1 : (mode == 2'h1) ? 2 : 4;
    w = 48 / n;
    for (int k = 0; k < n; k++) begin
      aw = (n == 1) ? 19 : (n == 2) ? (k ? 8 : 11) : (k ? 4 : 7);
      bw = (n == 1) ? 18 : (n == 2) ? (k ? 8 : 10) : (k ? 4 : 6);
      p = ext(a >> ao, aw, sgn) * ext(b >> bo, bw, sgn);
      ca = (op == 2'h2) ? longint'(prev >> (k * w)) : longint'(c >> (k * w));
      s = (op == 2'h1 || op == 2'h2) ? (sub[k] ? ca - p : ca + p) : p;
      t = ext(s, w, sgn) >>> sh[4*k +: 4];
      r = r | 48'((t & ((64'sd1 << w) - 1)) << (k * w));
      ao += aw;
      bo += bw;
    end
    return r;
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // One operation, registered at the next edge; float results come from the caller
  task automatic do_op(input logic [1:0] m, input logic [1:0] o, input logic [3:0] su, input logic [15:0] s,
                       input logic [18:0] x, input logic [17:0] y, input logic [47:0] z, input logic [47:0] fx);
    mode = m;
    op = o;
    sub = su;
    sh = s;
    a = x;
    b = y;
    c = z;
    expv = (m == 2'h3) ? fx : model();
    i_fma_fabric.put(m, o, su, s, x, y, z);
    @(posedge mclk_in);
    #1;
    check(result, expv);
    prev = expv;
  endtask

  // Reset held over n edges, result must read zero, then a neutral operation
  task automatic do_reset(input int n);
    rst_n_in = 1'b0;
    repeat (n) @(posedge mclk_in);
    #1;
    check(result, 48'h0);
    rst_n_in = 1'b1;
    prev = '0;
    do_op(2'h0, 2'h0, 4'h0, 16'h0, 19'h0, 18'h0, 48'h0, 48'h0);
  endtask

  task automatic end_sim();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset(6);
    $display("test reset done");
    do_op(2'h0, 2'h0, 4'h0, 16'h0, 19'h3, 18'h5, 48'h0, 48'h0);
    // Accumulate back to back, then a reset in mid-run
    repeat (3) do_op(2'h0, 2'h2, 4'h0, 16'h0, 19'h1, 18'h2, 48'h0, 48'h0);
    do_reset(1);
    // Unsigned subtract, quad and dual bypass with no shift
    do_op(2'h0, 2'h1, 4'h1, 16'h0, 19'h7, 18'h3, 48'h100, 48'h0);
    do_op(2'h2, 2'h0, 4'h0, 16'h0, 19'h7ffff, 18'h3ffff, 48'h0, 48'h0);
    do_op(2'h1, 2'h0, 4'h0, 16'h0, 19'h7ffff, 18'h3ffff, 48'h0, 48'h0);
    $display("test accumulate done");
    // Corners: most negative signed factors, full-scale quad with subtract and top shift
    sgn = 1'b1;
    i_fma_fabric.set_cfg(1'b1);
    do_op(2'h0, 2'h1, 4'h1, 16'h0, 19'h40000, 18'h20000, 48'h0, 48'h0);
    do_op(2'h2, 2'h1, 4'hf, 16'hffff, 19'h7ffff, 18'h3ffff, 48'h800800800800, 48'h0);
    do_op(2'h1, 2'h2, 4'h2, 16'h00f3, 19'h7ffff, 18'h3ffff, 48'h0, 48'h0);
    // Float: 1*2, 1+1*2, 1-1*2, then -1 accumulating 1*2; upper addend bits ignored
    do_op(2'h3, 2'h0, 4'h0, 16'h0, 19'h3f80, 18'h4000, 48'h0, 48'h4000);
    do_op(2'h3, 2'h1, 4'h0, 16'h0, 19'h3f80, 18'h4000, 48'h5a5a00003f80, 48'h4040);
    do_op(2'h3, 2'h1, 4'h1, 16'h0, 19'h3f80, 18'h4000, 48'h3f80, 48'hbf80);
    do_op(2'h3, 2'h2, 4'h0, 16'h0, 19'h3f80, 18'h4000, 48'h0, 48'h3f80);
    $display("test corners done");
    // Random traffic over all integer modes and ops, unsigned then signed
    for (int s = 0; s < 2; s++) begin
      sgn = s[0];
      i_fma_fabric.set_cfg(sgn);
      repeat (150) begin
        mode = 2'(rnd() % 3);
        op = 2'(rnd());
        sub = 4'(rnd());
        sh = 16'(rnd());
        a = 19'(rnd());
        b = 18'(rnd());
        c = {16'(rnd()), rnd()};
        do_op(mode, op, sub, sh, a, b, c, 48'h0);
      end
      $display("test random pass %0d done", s);
    end
    end_sim();
  end
endmodule
`default_nettype wire
